// *** vecirq_pkg.sv ***
// Operation
// [RULE1] eight sources, each with fixed top-memory vector
// [RULE2] simultaneous requests resolved by fixed rank
// [RULE3] service at instruction end; reset immediate
// [RULE4] reset level-sensitive, all others edge-triggered
// [RULE5] nonmaskable registers only on rising edge
// [RULE6] software picks edge for external a, b
// [RULE7] nonmaskable halts DMA after current byte finishes
// [RULE8] HDLC keeps running during nonmaskable service
// [RULE9] reset, nonmaskable unmaskable; others individually enabled
// [RULE10] maskable needs own enable and global enable
// [RULE11] pending set on trigger even when disabled
// [RULE12] one independent pending bit per vector, unordered
// [RULE13] pending register readable and writable by software
// [RULE14] external maskable pending bits auto-cleared on service
// [RULE15] software clears on-chip peripheral pending flags
// [RULE16] acknowledge pushes PC, stack pointer up twice
// [RULE17] acknowledge clears global interrupt enable
// [RULE18] PC loaded from selected vector word
// [RULE19] return pops PC and sets global enable
// [RULE20] software may set global enable for nesting
// [RULE21] reset tristates ports, fetches reset vector
// [RULE22] low level on reset pin requests reset
// [RULE23] external inputs synchronised, one pending per edge
package vecirq_pkg;

  localparam int VECIRQ_NSRC = 8;
  localparam int VECIRQ_AW = 16;
  localparam int VECIRQ_DW = 16;
  localparam int VECIRQ_RAW = 4;

  // source ranks, lower wins
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam logic [2:0] SRC_NMI = 3'h1;
  localparam logic [2:0] SRC_EXT_A = 3'h2;
  localparam logic [2:0] SRC_EXT_B = 3'h3;
  localparam logic [2:0] SRC_HDLC_ERR = 3'h4;
  localparam logic [2:0] SRC_TIMER = 3'h5;
  localparam logic [2:0] SRC_UART = 3'h6;
  localparam logic [2:0] SRC_EOM = 3'h7;

  // vector word of rank r sits at VEC_TOP - 2*r
  localparam logic [15:0] VEC_TOP = 16'hfffe;

  // register byte addresses
  localparam logic [3:0] REG_ENABLE = 4'h0;
  localparam logic [3:0] REG_PENDING = 4'h4;
  localparam logic [3:0] REG_POLARITY = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // enable and polarity register layout
  localparam int EN_GIE_BIT = 0;
  localparam int POL_EXT_A_BIT = 0;
  localparam int POL_EXT_B_BIT = 1;

  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PENDING_RST = 8'h00;
  localparam logic [1:0] POLARITY_RST = 2'h0;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } vecirq_mem_req_s;

endpackage

// *** vecirq_unit.sv ***
`timescale 1ns/1ps
module vecirq_unit
  import vecirq_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [VECIRQ_RAW-1:0] reg_addr_i,
  input wire logic [VECIRQ_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [VECIRQ_DW-1:0] reg_rdata_o,
  // device pins
  input wire logic reset_pin_n_i,
  input wire logic nmi_pin_i,
  input wire logic ext_int_a_i,
  input wire logic ext_int_b_i,
  // on-chip peripheral requests
  input wire logic hdlc_dma_err_i,
  input wire logic timer_ovf_i,
  input wire logic uart_irq_i,
  input wire logic eom_i,
  // processor core sequencer
  input wire logic instr_done_i,
  input wire logic [VECIRQ_AW-1:0] pc_i,
  input wire logic [VECIRQ_AW-1:0] sp_i,
  input wire logic return_from_interrupt_i,
  input wire logic mem_rdy_i,
  input wire logic [VECIRQ_DW-1:0] mem_rdata_i,
  output vecirq_mem_req_s mem_req_o,
  output logic sp_inc2_o,
  output logic sp_dec2_o,
  output logic pc_load_o,
  output logic [VECIRQ_AW-1:0] pc_value_o,
  output logic core_rst_o,
  output logic ports_hiz_o,
  output logic in_service_o,
  // dma and hdlc
  input wire logic dma_byte_busy_i,
  output logic dma_halt_o,
  output logic hdlc_run_o
);

  typedef enum {
    ST_RESET,
    ST_IDLE,
    ST_DMA_WAIT,
    ST_PUSH,
    ST_VEC_RD,
    ST_LOAD
  } vecirq_state_e;

  function automatic logic [2:0] pick_rank(input logic [7:0] req);
    logic [2:0] r;
    r = 3'h7;
    for (int i = VECIRQ_NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vec_addr(input logic [2:0] rank);
    return VEC_TOP - {12'h000, rank, 1'b0};
  endfunction

  function automatic logic edge_hit(input logic now, input logic prev, input logic falling);
    return falling ? (prev & ~now) : (~prev & now);
  endfunction

  vecirq_state_e state_q, state_d;

  logic [7:0] enable_q, enable_d;
  logic [7:0] pending_q, pending_d;
  logic [1:0] polarity_q, polarity_d;
  logic [2:0] rank_q, rank_d;
  logic [VECIRQ_DW-1:0] reg_rdata_q;
  vecirq_mem_req_s mem_req_q, mem_req_d;
  logic sp_inc2_q, sp_dec2_q, pc_load_q;
  logic [VECIRQ_AW-1:0] pc_value_q, pc_value_d;
  logic core_rst_q;
  logic in_service_q, in_service_d;

  // pin synchronisers: stage 1 is read only by stage 2
  logic rst_s1_q, rst_s2_q;
  logic nmi_s1_q, nmi_s2_q, nmi_s3_q;
  logic exa_s1_q, exa_s2_q, exa_s3_q;
  logic exb_s1_q, exb_s2_q, exb_s3_q;
  // on-chip lines share the clock, one delay for edges
  logic hdlc_p_q, tmr_p_q, uart_p_q, eom_p_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
      exa_s1_q <= 1'b0;
      exa_s2_q <= 1'b0;
      exa_s3_q <= 1'b0;
      exb_s1_q <= 1'b0;
      exb_s2_q <= 1'b0;
      exb_s3_q <= 1'b0;
      hdlc_p_q <= 1'b0;
      tmr_p_q <= 1'b0;
      uart_p_q <= 1'b0;
      eom_p_q <= 1'b0;
    end else begin
      rst_s1_q <= ~reset_pin_n_i;
      rst_s2_q <= rst_s1_q;
      nmi_s1_q <= nmi_pin_i; // [RULE23]
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
      exa_s1_q <= ext_int_a_i; // [RULE23]
      exa_s2_q <= exa_s1_q;
      exa_s3_q <= exa_s2_q;
      exb_s1_q <= ext_int_b_i; // [RULE23]
      exb_s2_q <= exb_s1_q;
      exb_s3_q <= exb_s2_q;
      hdlc_p_q <= hdlc_dma_err_i;
      tmr_p_q <= timer_ovf_i;
      uart_p_q <= uart_irq_i;
      eom_p_q <= eom_i;
    end
  end

  // trigger conditions
  wire reset_req = rst_s2_q; // [RULE22]
  wire nmi_edge = edge_hit(nmi_s2_q, nmi_s3_q, 1'b0); // [RULE5]
  wire exa_edge = edge_hit(exa_s2_q, exa_s3_q, polarity_q[POL_EXT_A_BIT]); // [RULE6]
  wire exb_edge = edge_hit(exb_s2_q, exb_s3_q, polarity_q[POL_EXT_B_BIT]); // [RULE6]
  wire hdlc_edge = hdlc_dma_err_i & ~hdlc_p_q; // [RULE8]
  wire tmr_edge = timer_ovf_i & ~tmr_p_q;
  wire uart_edge = uart_irq_i & ~uart_p_q;
  wire eom_edge = eom_i & ~eom_p_q;

  // bit 0 follows the reset level, the rest latch one edge each
  wire [7:0] trig = {eom_edge, uart_edge, tmr_edge, hdlc_edge,
                     exb_edge, exa_edge, nmi_edge, 1'b0}; // [RULE4] [RULE23]

  // eligibility
  wire global_int_enable = enable_q[EN_GIE_BIT];
  wire [7:0] mask = {{6{global_int_enable}} & enable_q[7:2], 2'b11}; // [RULE9] [RULE10]
  wire [7:0] eligible = pending_q & mask;
  wire [7:0] maskable_req = {eligible[7:2], 1'b0, 1'b0};
  // rank 0 is handled by the reset path, never by the sequencer
  wire [7:0] seq_req = {maskable_req[7:2], eligible[1], 1'b0};
  wire seq_valid = |seq_req;
  wire [2:0] win_rank = pick_rank(seq_req); // [RULE2] [RULE12]

  // register port decode
  wire sel_enable = (reg_addr_i == REG_ENABLE);
  wire sel_pending = (reg_addr_i == REG_PENDING);
  wire sel_polarity = (reg_addr_i == REG_POLARITY);
  wire sel_status = (reg_addr_i == REG_STATUS);
  wire wr_enable = reg_wr_i & sel_enable;
  wire wr_pending = reg_wr_i & sel_pending;
  wire wr_polarity = reg_wr_i & sel_polarity;

  wire [VECIRQ_DW-1:0] status_word = {8'h00, 1'b0, rank_q, 1'b0,
                                      in_service_q, dma_halt_o, core_rst_q};
  wire [VECIRQ_DW-1:0] rd_mux =
    sel_enable ? {8'h00, enable_q} :
    sel_pending ? {8'h00, pending_q} :
    sel_polarity ? {14'h0000, polarity_q} :
    sel_status ? status_word : 16'h0000;

  // sequencer events
  wire take = (state_q == ST_IDLE) & instr_done_i & seq_valid; // [RULE3]
  wire nmi_hold = take & (win_rank == SRC_NMI) & dma_byte_busy_i; // [RULE7]
  wire ack = (state_q == ST_PUSH) & mem_rdy_i;
  wire return_from_interrupt_ok = (state_q == ST_IDLE) & return_from_interrupt_i & ~take;

  // pending bits: a trigger always wins over a clear
  always_comb begin
    pending_d = pending_q;
    if (wr_pending) begin
      pending_d = reg_wdata_i[7:0]; // [RULE13]
    end
    if (ack && (rank_q == SRC_EXT_A || rank_q == SRC_EXT_B || rank_q == SRC_NMI)) begin
      pending_d[rank_q] = 1'b0; // [RULE14]
    end
    // peripherals (ranks 4..7) stay set until software clears them [RULE15]
    pending_d = pending_d | trig; // [RULE11]
    pending_d[SRC_RESET] = reset_req; // [RULE4]
  end

  // enable and global enable
  always_comb begin
    enable_d = enable_q;
    if (wr_enable) begin
      enable_d = reg_wdata_i[7:0]; // [RULE20]
    end
    if (return_from_interrupt_ok) begin
      enable_d[EN_GIE_BIT] = 1'b1; // [RULE19]
    end
    if (ack) begin
      enable_d[EN_GIE_BIT] = 1'b0; // [RULE17]
    end
    enable_d[1:1] = 1'b0;
  end

  always_comb begin
    polarity_d = polarity_q;
    if (wr_polarity) begin
      polarity_d = reg_wdata_i[1:0]; // [RULE6]
    end
  end

  // service sequencer
  always_comb begin
    state_d = state_q;
    rank_d = rank_q;
    mem_req_d = '0;
    pc_value_d = pc_value_q;
    in_service_d = in_service_q;
    case (state_q)
      ST_RESET: begin
        rank_d = SRC_RESET;
        if (!reset_req) begin
          state_d = ST_VEC_RD; // [RULE21]
          mem_req_d.rd = 1'b1;
          mem_req_d.addr = vec_addr(SRC_RESET);
        end
      end
      ST_IDLE: begin
        if (return_from_interrupt_ok) begin
          in_service_d = 1'b0;
        end
        if (take) begin
          rank_d = win_rank;
          if (nmi_hold) begin
            state_d = ST_DMA_WAIT; // [RULE7]
          end else begin
            state_d = ST_PUSH;
            mem_req_d.wr = 1'b1;
            mem_req_d.addr = sp_i;
            mem_req_d.wdata = pc_i; // [RULE16]
          end
        end
      end
      ST_DMA_WAIT: begin
        if (!dma_byte_busy_i) begin
          state_d = ST_PUSH;
          mem_req_d.wr = 1'b1;
          mem_req_d.addr = sp_i;
          mem_req_d.wdata = pc_i; // [RULE16]
        end
      end
      ST_PUSH: begin
        if (mem_rdy_i) begin
          state_d = ST_VEC_RD;
          mem_req_d.rd = 1'b1;
          mem_req_d.addr = vec_addr(rank_q); // [RULE1]
          in_service_d = 1'b1;
        end else begin
          mem_req_d = mem_req_q;
        end
      end
      ST_VEC_RD: begin
        if (mem_rdy_i) begin
          state_d = ST_LOAD;
          pc_value_d = mem_rdata_i; // [RULE18]
        end else begin
          mem_req_d = mem_req_q;
        end
      end
      ST_LOAD: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // reset pin overrides any step in progress
    if (reset_req) begin
      state_d = ST_RESET; // [RULE3] [RULE21]
      mem_req_d = '0;
      in_service_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_RESET;
      rank_q <= SRC_RESET;
      enable_q <= ENABLE_RST;
      pending_q <= PENDING_RST;
      polarity_q <= POLARITY_RST;
      mem_req_q <= '0;
      pc_value_q <= '0;
      in_service_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rank_q <= rank_d;
      enable_q <= enable_d;
      pending_q <= pending_d;
      polarity_q <= polarity_d;
      mem_req_q <= mem_req_d;
      pc_value_q <= pc_value_d;
      in_service_q <= in_service_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sp_inc2_q <= 1'b0;
      sp_dec2_q <= 1'b0;
      pc_load_q <= 1'b0;
      core_rst_q <= 1'b1;
      reg_rdata_q <= '0;
    end else begin
      sp_inc2_q <= ack; // [RULE16]
      sp_dec2_q <= return_from_interrupt_ok; // [RULE19]
      pc_load_q <= (state_q == ST_VEC_RD) & mem_rdy_i & ~reset_req; // [RULE18]
      core_rst_q <= (state_d == ST_RESET); // [RULE21]
      reg_rdata_q <= reg_rd_i ? rd_mux : 16'h0000;
    end
  end

  // dma halts from nonmaskable acceptance until the vector is loaded
  assign dma_halt_o = (state_q != ST_IDLE) && (state_q != ST_RESET) &&
                      (rank_q == SRC_NMI); // [RULE7]
  // hdlc never stops for interrupt service; its errors keep pending
  assign hdlc_run_o = ~core_rst_q; // [RULE8]

  assign reg_rdata_o = reg_rdata_q;
  assign mem_req_o = mem_req_q;
  assign sp_inc2_o = sp_inc2_q;
  assign sp_dec2_o = sp_dec2_q;
  assign pc_load_o = pc_load_q;
  assign pc_value_o = pc_value_q;
  assign core_rst_o = core_rst_q;
  assign ports_hiz_o = core_rst_q; // [RULE21]
  assign in_service_o = in_service_q;

endmodule

// *** vecirq_sva.sv ***
`timescale 1ns/1ps
module vecirq_sva
  import vecirq_pkg::*;
(
  // clock, reset and core inputs
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] sp_i,
  input wire logic return_from_interrupt_i,
  input wire logic mem_rdy_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic dma_byte_busy_i,
  // unit outputs
  input wire vecirq_mem_req_s mem_req_o,
  input wire logic sp_inc2_o,
  input wire logic sp_dec2_o,
  input wire logic pc_load_o,
  input wire logic [15:0] pc_value_o,
  input wire logic core_rst_o,
  input wire logic ports_hiz_o,
  input wire logic in_service_o,
  input wire logic dma_halt_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence push_s;
    mem_req_o.wr && mem_rdy_i;
  endsequence
  sequence fetch_s;
    mem_req_o.rd && mem_rdy_i;
  endsequence
  push_step_a: assert property (push_s |=> sp_inc2_o && in_service_o)
    else $error("stack step missing after push");
  vec_fetch_a: assert property (push_s |=> mem_req_o.rd && mem_req_o.addr[15:4] == 12'hfff)
    else $error("vector fetch address wrong");
  pc_load_a: assert property (fetch_s |=> pc_load_o && pc_value_o == $past(mem_rdata_i))
    else $error("vector word not loaded");
  push_data_a: assert property ($rose(mem_req_o.wr) |->
    mem_req_o.addr == $past(sp_i) && mem_req_o.wdata == $past(pc_i))
    else $error("push address or data wrong");
  pop_step_a: assert property (sp_dec2_o |-> $past(return_from_interrupt_i))
    else $error("stack pop without return");
  req_hold_a: assert property (mem_req_o.wr && !mem_rdy_i |=> $stable(mem_req_o))
    else $error("push request dropped early");
  dma_wait_a: assert property ($rose(mem_req_o.wr) && dma_halt_o |-> !$past(dma_byte_busy_i))
    else $error("push before dma byte finished");
  port_hiz_a: assert property (ports_hiz_o == core_rst_o)
    else $error("ports not floated with core reset");
endmodule

bind vecirq_unit vecirq_sva vecirq_sva_inst (.*);

// *** vecirq_mem_model.sv ***
`timescale 1ns/1ps
module vecirq_mem_model
  import vecirq_pkg::*;
(
  // clock and pacing
  input wire logic core_clk_i,
  input wire logic slow_i,
  // memory side of the unit
  input wire vecirq_mem_req_s mem_req_i,
  output logic mem_rdy_o,
  output logic [15:0] mem_rdata_o
);
  logic [1:0] wait_q = 2'h0;
  logic [15:0] noise_q = 16'h0;
  wire busy = mem_req_i.rd | mem_req_i.wr;
  // slow mode adds two wait cycles to every access
  assign mem_rdy_o = busy && (wait_q == (slow_i ? 2'h2 : 2'h0));
  // read bus is zero outside the ready cycle, never the last word
  assign mem_rdata_o = mem_rdy_o ? ~mem_req_i.addr : noise_q;
  always @(posedge core_clk_i) begin
    noise_q <= ~noise_q + 16'h1;
    wait_q <= (busy && !mem_rdy_o) ? wait_q + 2'h1 : 2'h0;
  end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import vecirq_pkg::*;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0, reg_rdata_o, pc_i = 16'h0, sp_i = 16'h0;
  logic reset_pin_n_i = 1'b1, nmi_pin_i = 1'b0, ext_int_a_i = 1'b0, ext_int_b_i = 1'b0;
  logic hdlc_dma_err_i = 1'b0, timer_ovf_i = 1'b0, uart_irq_i = 1'b0, eom_i = 1'b0;
  logic instr_done_i = 1'b0, return_from_interrupt_i = 1'b0, dma_byte_busy_i = 1'b0, slow = 1'b0;
  logic rd_d = 1'b0, pol, mem_rdy_i, sp_inc2_o, sp_dec2_o, pc_load_o, core_rst_o;
  logic ports_hiz_o, in_service_o, dma_halt_o, hdlc_run_o;
  logic [15:0] mem_rdata_i, pc_value_o;
  vecirq_mem_req_s mem_req_o;
  logic [15:0] rd_exp[$], rd_msk[$], pc_exp[$];
  int seed = 41296, miscompares = 0, comparisons = 0, cycles = 0;

  vecirq_unit vecirq_unit_inst (.*);
  vecirq_mem_model vecirq_mem_model_inst (.core_clk_i, .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_rdy_o(mem_rdy_i), .mem_rdata_o(mem_rdata_i));

  task automatic cmp(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    tick(1);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    tick(1);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    rd_exp.push_back(e);
    rd_msk.push_back(m);
    tick(1);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    tick(1);
    reg_rd_i <= 1'b0;
  endtask
  task load(input logic [15:0] e);
    int n;
    pc_exp.push_back(e);
    for (n = 0; n < 60 && pc_exp.size() > 0; n++) tick(1);
    if (pc_exp.size() > 0) cmp("pc_load_o", 16'h0, 16'h1);
    pc_exp.delete();
    tick(2);
  endtask
  task ret();
    return_from_interrupt_i <= 1'b1;
    tick(1);
    return_from_interrupt_i <= 1'b0;
    tick(1);
  endtask

  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    rd_d <= reg_rd_i;
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // checked mid-cycle so registered outputs have settled
  always @(negedge core_clk_i) begin
    if (rd_d) cmp("reg_rdata_o", reg_rdata_o & rd_msk.pop_front(), rd_exp.pop_front());
    if (pc_load_o !== 1'b0) cmp("pc_value_o", pc_value_o, pc_exp.pop_front());
  end

  initial begin
    pc_i = 16'($random(seed));
    sp_i = 16'($random(seed));
    tick(2);
    sys_rst_i <= 1'b0;
    load(~VEC_TOP);
    rd(REG_ENABLE, 16'h0000, 16'hffff);
    rd(REG_POLARITY, 16'h0000, 16'hffff);
    rd(4'h2, 16'h0000, 16'hffff);
    $display("test reset done");
    {eom_i, uart_irq_i, timer_ovf_i, hdlc_dma_err_i, ext_int_a_i} <= 5'h1f;
    tick(1);
    {eom_i, uart_irq_i, timer_ovf_i, hdlc_dma_err_i} <= 4'h0;
    tick(4);
    rd(REG_PENDING, 16'h00f4, 16'hfffe);
    ext_int_a_i <= 1'b0;
    wr(REG_PENDING, 16'h0000);
    tick(4);
    rd(REG_PENDING, 16'h0000, 16'hfffe);
    $display("test pending done");
    wr(REG_ENABLE, 16'h0005);
    instr_done_i <= 1'b1;
    ext_int_a_i <= 1'b1;
    load(~16'hfffa);
    rd(REG_ENABLE, 16'h0004, 16'hffff);
    rd(REG_PENDING, 16'h0000, 16'hfffe);
    ret();
    rd(REG_ENABLE, 16'h0005, 16'hffff);
    $display("test service done");
    instr_done_i <= 1'b0;
    pol = 1'($random(seed));
    wr(REG_POLARITY, {14'h0, pol, 1'b0});
    ext_int_b_i <= pol;
    wr(REG_ENABLE, 16'h0049);
    ext_int_b_i <= ~pol;
    uart_irq_i <= 1'b1;
    tick(4);
    uart_irq_i <= 1'b0;
    instr_done_i <= 1'b1;
    load(~16'hfff8);
    rd(REG_PENDING, 16'h0040, 16'hfffe);
    wr(REG_ENABLE, 16'h0049);
    load(~16'hfff2);
    $display("test rank done");
    slow <= 1'b1;
    dma_byte_busy_i <= 1'b1;
    nmi_pin_i <= 1'b1;
    tick(4);
    rd(REG_STATUS, 16'h0012, 16'h0072);
    @(negedge core_clk_i);
    cmp("hdlc_run_o", {15'h0000, hdlc_run_o}, 16'h0001);
    tick(2);
    dma_byte_busy_i <= 1'b0;
    load(~16'hfffc);
    nmi_pin_i <= 1'b0;
    wr(REG_PENDING, 16'h0000);
    tick(4);
    rd(REG_PENDING, 16'h0000, 16'hfffe);
    repeat (3) ret();
    $display("test nonmaskable done");
    reset_pin_n_i <= 1'b0;
    tick(4);
    rd(REG_STATUS, 16'h0001, 16'h0001);
    @(negedge core_clk_i);
    cmp("hdlc_run_o", {15'h0000, hdlc_run_o}, 16'h0000);
    cmp("ports_hiz_o", {15'h0000, ports_hiz_o}, 16'h0001);
    reset_pin_n_i <= 1'b1;
    load(~VEC_TOP);
    $display("test pin reset done");
    report_and_stop();
  end
endmodule
